// >>> hw/swtc_cfg.svh
// offsets, field positions, reset values and timing counts
`ifndef SWTC_CFG_SVH
`define SWTC_CFG_SVH
// register byte offsets
`define SWTC_A_CFG    8'h00
`define SWTC_A_WAKE   8'h04
`define SWTC_A_RETX   8'h08
`define SWTC_A_THR    8'h0C
`define SWTC_A_MISC   8'h10
`define SWTC_A_EEP    8'h14
`define SWTC_A_ID     8'h18
`define SWTC_A_STAT   8'h1C
`define SWTC_A_TGD    8'h20
// cfg register bit positions
`define SWTC_B_PWAKE  0
`define SWTC_B_PRETX  1
`define SWTC_B_RESALT 2
`define SWTC_B_AD2INT 3
`define SWTC_B_SCOINV 4
`define SWTC_B_MFROK  5
`define SWTC_B_SRST   6
// reset values
`define SWTC_R_WAKE   16'h0001
`define SWTC_R_RMIN   8'h07
`define SWTC_R_RMAX   8'h0E
`define SWTC_R_TH0    10'h006
`define SWTC_R_TH1    10'h005
`define SWTC_R_TH2    10'h00E
`define SWTC_R_MASK   4'h0
`define SWTC_R_DLY    8'h01
`define SWTC_R_EDGE   2'h3
`define SWTC_R_LFSR   16'hACE1
// programmed wake cycle limits, seconds
`define SWTC_WAKE_MIN 16'h0001
`define SWTC_WAKE_MAX 16'hFFFE
// strap wake cycles, seconds
`define SWTC_CW_A     16'h0001
`define SWTC_CW_B     16'h000A
`define SWTC_CW_C     16'h0064
// strap retransmit intervals, wake-ups
`define SWTC_CP_LO1   8'h07
`define SWTC_CP_HI1   8'h0E
`define SWTC_CP_LO2   8'h46
`define SWTC_CP_HI2   8'h8C
// teach-in telegram type
`define SWTC_ORG      8'h07
// clock period and one second, in ns
`define SWTC_CLK_NS   100
`define SWTC_SEC_NS   1000000000
`define SWTC_TICK_CYC (`SWTC_SEC_NS / `SWTC_CLK_NS)
`endif

// >>> hw/swtc_pkg.sv
// types shared by the sensor wake and telegram control
package swtc_pkg;
  // active configuration set
  typedef struct packed {
    logic [15:0] wake_s;
    logic [7:0]  rmin;
    logic [7:0]  rmax;
    logic        prog_wake;
    logic        prog_retx;
    logic        res_alt;
    logic        ad2_int;
    logic        sco_inv;
    logic        mfr_ok;
    logic [9:0]  th0;
    logic [9:0]  th1;
    logic [9:0]  th2;
    logic [3:0]  mask;
    logic [7:0]  delay;
    logic [1:0]  edge0;
    logic [1:0]  edge1;
    logic [23:0] equipment_profile_code;
  } swtc_cfg_t;
  // pin inputs, 1 = open / above
  typedef struct packed {
    logic       above_on;
    logic       above_off;
    logic       sleep;
    logic [1:0] wake;
    logic [1:0] cw;
    logic [1:0] cp;
    logic [3:0] di;
  } swtc_pin_t;
  // telegram handed to the modem
  typedef struct packed {
    logic        teach;
    logic        retx;
    logic [7:0]  telegram_type_field;
    logic [31:0] data;
    logic [31:0] id;
  } swtc_tg_t;
  typedef enum {ST_OFF, ST_RUN, ST_SHUT} swtc_pwr_t;
endpackage : swtc_pkg

// >>> hw/swtc_top.sv
// sensor wake, retransmit, charge control and telegram control
//
// Functional notes
// - above turn-on, enable regulator, watchdog, wake
// - at or below turn-off, start shutdown
// - charge output floats until first turn-on
// - charge output follows turn-on comparator
// - charge output frozen during deep sleep
// - wake cycle from two straps
// - straps re-sampled at every wake-up
// - counter decrements, zero sends retransmission
// - retransmit strap gives every, 7-14, 70-140, never
// - wake pin wake-up transmits on configured edges
// - reload random count after each transmission
// - programmed settings win, loaded at reset only
// - programmed wake cycle 1 to 65534 s
// - min equals max gives fixed count
// - three channel thresholds, defaults 6, 5, 14
// - resolution default 8/8/8, option 10/6/8
// - mask ignores selected digital input changes
// - sensor power delay 0-508 ms, invertible
// - channel two source pin or quarter supply
// - any wake pin change wakes, learn pin only with code; edges select sending
// - teach-in replaces normal with code programmed and input three low or learn pin transmitting
// - teach-in fields type, learn bits, inputs, id
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "swtc_cfg.svh"

module swtc_top
  import swtc_pkg::*;
#(
  parameter int          TICK_CYCLES = `SWTC_TICK_CYC,
  parameter logic [31:0] MODULE_ID   = 32'h0000_0001 // arbitrary
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output      logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output      logic        wready,
  output      logic [1:0]  bresp,
  output      logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output      logic        arready,
  output      logic [31:0] rdata,
  output      logic [1:0]  rresp,
  output      logic        rvalid,
  input  wire logic        rready,
  input  wire swtc_pin_t   pin_in,
  output      logic        cco_out,
  output      logic        cco_oe,
  output      logic        ulp_supply_en,
  output      logic        watchdog_en,
  output      logic        wake_circ_en,
  output      logic        shutdown_req,
  output      swtc_cfg_t   cfg_act,
  output      swtc_tg_t    tg,
  output      logic        tg_valid
);

  // byte-lane merge for partial writes
  function automatic logic [31:0] mrg(input logic [31:0] o,
                                      input logic [31:0] n,
                                      input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
    end
    return r;
  endfunction : mrg

  // mapped address check, shared by both channels
  function automatic logic addr_ok(input logic [7:0] a);
    return a <= `SWTC_A_TGD && a[1:0] == 2'h0;
  endfunction : addr_ok

  // register view, used for reads and write merges
  function automatic logic [31:0] reg_word(input logic [7:0] a,
                                           input swtc_cfg_t  c,
                                           input logic [31:0] st,
                                           input logic [31:0] td);
    case (a)
      `SWTC_A_CFG:  return {26'h0, c.mfr_ok, c.sco_inv, c.ad2_int,
                            c.res_alt, c.prog_retx, c.prog_wake};
      `SWTC_A_WAKE: return {16'h0, c.wake_s};
      `SWTC_A_RETX: return {16'h0, c.rmax, c.rmin};
      `SWTC_A_THR:  return {2'h0, c.th2, c.th1, c.th0};
      `SWTC_A_MISC: return {16'h0, c.edge1, c.edge0, c.delay, c.mask};
      `SWTC_A_EEP:  return {8'h0, c.equipment_profile_code};
      `SWTC_A_ID:   return MODULE_ID;
      `SWTC_A_STAT: return st;
      `SWTC_A_TGD:  return td;
      default:      return 32'h0;
    endcase
  endfunction : reg_word

  // uniform pick in [lo, hi]; lo above hi gives lo
  function automatic logic [7:0] rand_pick(input logic [7:0]  lo,
                                           input logic [7:0]  hi,
                                           input logic [15:0] r);
    logic [8:0]  span;
    logic [15:0] m;
    span = (hi < lo) ? 9'h001 : 9'({1'b0, hi} - {1'b0, lo} + 9'h001);
    m    = r % {7'h0, span};
    return 8'(lo + m[7:0]);
  endfunction : rand_pick

  // default set, also what nonvolatile store holds after reset
  localparam swtc_cfg_t CFG_RST = '{
    wake_s: `SWTC_R_WAKE, rmin: `SWTC_R_RMIN, rmax: `SWTC_R_RMAX,
    prog_wake: 1'b0, prog_retx: 1'b0, res_alt: 1'b0, ad2_int: 1'b0,
    sco_inv: 1'b0, mfr_ok: 1'b0, th0: `SWTC_R_TH0, th1: `SWTC_R_TH1,
    th2: `SWTC_R_TH2, mask: `SWTC_R_MASK, delay: `SWTC_R_DLY,
    edge0: `SWTC_R_EDGE, edge1: `SWTC_R_EDGE, equipment_profile_code: 24'h0};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  swtc_pin_t   s1, s2, s3;    // three-stage pin capture
  swtc_pin_t   pc;            // agreed pin levels
  swtc_cfg_t   cfg_nv;        // store written by software
  swtc_pwr_t   pwr;           // threshold detector state
  logic        cco_started;   // first turn-on seen
  logic        load;          // apply stored config
  logic        soft_rst;      // software module reset pulse
  logic [1:0]  cw_q, cp_q;    // straps as last sampled
  logic [1:0]  wake_d;        // wake pins, previous cycle
  logic [3:0]  di_last;       // inputs at last telegram
  logic [23:0] tick_cnt;      // one-second prescaler
  logic [15:0] sec_cnt;       // seconds since last wake
  logic [7:0]  retx_cnt;      // wake-ups to retransmission
  logic [15:0] lfsr;          // random source
  logic [7:0]  aw_addr;       // held write address
  logic        aw_hold, w_hold;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_go;         // both halves present
  logic [31:0] wv;            // merged write value
  logic [31:0] stat;          // status word
  logic        run, sec_tick, timer_wake;
  logic [15:0] period;        // wake cycle in seconds
  logic        cyclic;        // cyclic wake enabled
  logic [7:0]  r_lo, r_hi;    // retransmit interval
  logic        r_never;
  logic [1:0]  rise, fall, pin_chg, pin_tx_v;
  logic        pin_tx, retx_due, di_chg, send, teach, wake_any;

  // pins: three flops, take a change once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      pc <= '0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      pc <= (pc & (s2 ^ s3)) | (s3 & ~(s2 ^ s3));
    end
  end

  // threshold detector state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr <= ST_OFF;
    end else begin
      case (pwr)
        ST_OFF:  if (pc.above_on) pwr <= ST_RUN;
        ST_RUN:  if (!pc.above_off) pwr <= ST_SHUT;
        ST_SHUT: if (pc.above_on) pwr <= ST_RUN;
        default: pwr <= ST_OFF;
      endcase
    end
  end

  assign run = (pwr == ST_RUN);

  // supply enables and shutdown request, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ulp_supply_en <= 1'b0;
      watchdog_en   <= 1'b0;
      wake_circ_en  <= 1'b0;
      shutdown_req  <= 1'b0;
    end else begin
      ulp_supply_en <= run;
      watchdog_en   <= run;
      wake_circ_en  <= run;
      shutdown_req  <= (pwr == ST_SHUT);
    end
  end

  a_pwr_enable: assert property (
    pwr == ST_OFF && pc.above_on |=> ##1 ulp_supply_en && watchdog_en)
    else $error("enables not raised after turn-on");
  a_shut_start: assert property (
    run && !pc.above_off |=> ##1 shutdown_req && !wake_circ_en)
    else $error("shutdown not started");

  // charge control: floats until first turn-on, frozen in deep sleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cco_started <= 1'b0;
      cco_oe      <= 1'b0;
      cco_out     <= 1'b0;
    end else begin
      if (pc.above_on) cco_started <= 1'b1;
      cco_oe <= cco_started;
      // below turn-off it simply drives low, which is allowed
      if (!pc.sleep) cco_out <= pc.above_on;
    end
  end

  a_cco_float: assert property (
    !cco_started |=> !cco_oe)
    else $error("charge output driven before turn-on");
  a_cco_level: assert property (
    cco_started && !pc.sleep |=> cco_oe && cco_out == $past(pc.above_on))
    else $error("charge output not following");
  a_cco_hold: assert property (
    pc.sleep |=> $stable(cco_out))
    else $error("charge output moved in deep sleep");

  // one-second tick; wake-up timer counts seconds
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      tick_cnt <= 24'h0;
    end else if (sec_tick) begin
      tick_cnt <= 24'h0;
    end else begin
      tick_cnt <= 24'(tick_cnt + 24'h1);
    end
  end

  assign sec_tick = run && tick_cnt == 24'(TICK_CYCLES - 1);

  // wake cycle: programmed value wins, else straps
  always_comb begin
    cyclic = 1'b1;
    period = cfg_act.wake_s;
    if (!cfg_act.prog_wake) begin
      case (cw_q)
        2'b11:   period = `SWTC_CW_A;
        2'b10:   period = `SWTC_CW_B;
        2'b01:   period = `SWTC_CW_C;
        default: cyclic = 1'b0;
      endcase
    end
  end

  assign timer_wake = sec_tick && cyclic && sec_cnt >= 16'(period - 16'h1);

  // seconds since last wake, restarted by any wake
  always_ff @(posedge aclk) begin
    if (!aresetn || load) begin
      sec_cnt <= 16'h0;
    end else if (wake_any) begin
      sec_cnt <= 16'h0;
    end else if (sec_tick) begin
      sec_cnt <= 16'(sec_cnt + 16'h1);
    end
  end

  // retransmit interval: programmed limits, else straps
  always_comb begin
    r_never = 1'b0;
    r_lo    = cfg_act.rmin;
    r_hi    = cfg_act.rmax;
    if (!cfg_act.prog_retx) begin
      case (cp_q)
        2'b11:   begin r_lo = 8'h01; r_hi = 8'h01; end
        2'b10:   begin r_lo = `SWTC_CP_LO1; r_hi = `SWTC_CP_HI1; end
        2'b01:   begin r_lo = `SWTC_CP_LO2; r_hi = `SWTC_CP_HI2; end
        default: r_never = 1'b1;
      endcase
    end
  end

  // wake pins: every change wakes (learn pin only with code), configured edges transmit
  always_comb begin
    rise = pc.wake & ~wake_d;
    fall = ~pc.wake & wake_d;
    // learn pin is dead unless a manufacturer code exists
    pin_chg = (rise | fall) & {cfg_act.mfr_ok, 1'b1};
    pin_tx_v[0] = (rise[0] & cfg_act.edge0[0]) |
                  (fall[0] & cfg_act.edge0[1]);
    pin_tx_v[1] = ((rise[1] & cfg_act.edge1[0]) |
                   (fall[1] & cfg_act.edge1[1])) & cfg_act.mfr_ok;
    pin_tx   = run && |pin_tx_v;
    wake_any = run && (timer_wake || |pin_chg);
    retx_due = run && timer_wake && !r_never &&
               retx_cnt <= 8'h01;
    di_chg   = run && timer_wake &&
               |((pc.di ^ di_last) & ~cfg_act.mask);
    send     = pin_tx || retx_due || di_chg;
    teach    = send && cfg_act.mfr_ok &&
               (!pc.di[3] || pin_tx_v[1]);
  end

  // previous wake levels and straps sampled at each wake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_d <= 2'h0;
      cw_q   <= 2'h3;
      cp_q   <= 2'h3;
    end else begin
      wake_d <= pc.wake;
      // power-up counts as a wake: pins are settled by then, not at load
      if (load || wake_any || (!run && pc.above_on)) begin
        cw_q <= pc.cw;
        cp_q <= pc.cp;
      end
    end
  end

  // free-running random source, taps 16,14,13,11
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lfsr <= `SWTC_R_LFSR;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  // retransmit countdown, random reload after each telegram
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      retx_cnt <= `SWTC_R_RMIN;
    end else if (load || send) begin
      retx_cnt <= rand_pick(r_lo, r_hi, lfsr);
    end else if (run && timer_wake && !r_never) begin
      retx_cnt <= 8'(retx_cnt - 8'h01);
    end
  end

  a_retx_reload: assert property (
    send && !r_never |=> retx_cnt >= $past(r_lo) &&
      (retx_cnt <= $past(r_hi) || $past(r_hi) < $past(r_lo)))
    else $error("reload outside interval");

  // telegram register and input snapshot
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tg       <= '0;
      tg_valid <= 1'b0;
      di_last  <= 4'h0;
    end else begin
      tg_valid <= send;
      if (send) begin
        di_last  <= pc.di;
        tg.teach <= teach;
        tg.retx  <= retx_due;
        tg.telegram_type_field   <= `SWTC_ORG;
        tg.id    <= MODULE_ID;
        if (teach) begin
          // eep, learn type 1, reserved 0, learn bit 0, inputs
          tg.data <= {cfg_act.equipment_profile_code, 1'b1, 3'b000, 1'b0,
                      pc.di[2:0]};
        end else begin
          tg.data <= {28'h0, pc.di};
        end
      end
    end
  end

  sequence s_retx_due;
    run ##0 timer_wake ##0 !r_never ##0 retx_cnt == 8'h01;
  endsequence
  sequence s_retx_sent;
    tg_valid ##0 tg.retx;
  endsequence
  a_retx_send: assert property (
    s_retx_due |=> s_retx_sent)
    else $error("retransmission not sent at zero");
  a_pin_tx: assert property (
    pin_tx |=> tg_valid)
    else $error("wake pin did not transmit");
  a_teach_fld: assert property (
    tg_valid && tg.teach |-> tg.telegram_type_field == `SWTC_ORG && tg.data[7] &&
      tg.data[6:3] == 4'h0)
    else $error("teach-in field wrong");
  a_teach_code: assert property (
    send && !cfg_act.mfr_ok |=> !tg.teach)
    else $error("teach-in without code");

  // write channel: address and data held independently
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 8'h0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= 2'b00;
    end else begin
      if (awvalid && awready) begin
        aw_addr <= awaddr;
        aw_hold <= 1'b1;
        awready <= 1'b0;
      end else if (!aw_hold && !bvalid) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        w_data <= wdata;
        w_strb <= wstrb;
        w_hold <= 1'b1;
        wready <= 1'b0;
      end else if (!w_hold && !bvalid) begin
        wready <= 1'b1;
      end
      if (wr_go) begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= addr_ok(aw_addr) ? 2'b00 : 2'b10;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  assign wr_go = aw_hold && w_hold && !bvalid;
  assign wv = mrg(reg_word(aw_addr, cfg_nv, stat, tg.data),
                  w_data, w_strb);

  // stored configuration, written over the bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_nv   <= CFG_RST;
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= 1'b0;
      if (wr_go) begin
        case (aw_addr)
          `SWTC_A_CFG: begin
            cfg_nv.prog_wake <= wv[`SWTC_B_PWAKE];
            cfg_nv.prog_retx <= wv[`SWTC_B_PRETX];
            cfg_nv.res_alt   <= wv[`SWTC_B_RESALT];
            cfg_nv.ad2_int   <= wv[`SWTC_B_AD2INT];
            cfg_nv.sco_inv   <= wv[`SWTC_B_SCOINV];
            cfg_nv.mfr_ok    <= wv[`SWTC_B_MFROK];
            soft_rst         <= wv[`SWTC_B_SRST];
          end
          `SWTC_A_WAKE: begin
            // out-of-range cycles are dropped, old value kept
            if (wv[15:0] >= `SWTC_WAKE_MIN &&
                wv[15:0] <= `SWTC_WAKE_MAX)
              cfg_nv.wake_s <= wv[15:0];
          end
          `SWTC_A_RETX: begin
            cfg_nv.rmin <= wv[7:0];
            cfg_nv.rmax <= wv[15:8];
          end
          `SWTC_A_THR: begin
            cfg_nv.th0 <= wv[9:0];
            cfg_nv.th1 <= wv[19:10];
            cfg_nv.th2 <= wv[29:20];
          end
          `SWTC_A_MISC: begin
            cfg_nv.mask  <= wv[3:0];
            cfg_nv.delay <= wv[11:4];
            cfg_nv.edge0 <= wv[13:12];
            cfg_nv.edge1 <= wv[15:14];
          end
          `SWTC_A_EEP: cfg_nv.equipment_profile_code <= wv[23:0];
          default: ;
        endcase
      end
    end
  end

  // active set copied only at reset release or module reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load    <= 1'b1;
      cfg_act <= CFG_RST;
    end else begin
      load <= soft_rst;
      if (load) cfg_act <= cfg_nv;
    end
  end

  a_cfg_reset_only: assert property (
    !load |=> $stable(cfg_act))
    else $error("config changed outside reset");

  // status word for software
  assign stat = {sec_cnt, retx_cnt, 3'h0, r_never, cco_oe, cco_out,
                 shutdown_req, ulp_supply_en};

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= 2'b00;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= reg_word(araddr, cfg_nv, stat, tg.data);
        rresp   <= addr_ok(araddr) ? 2'b00 : 2'b10;
      end else begin
        if (rvalid && rready) rvalid <= 1'b0;
        if (!rvalid) arready <= 1'b1;
      end
    end
  end

endmodule : swtc_top

// >>> dv/swtc_env.sv
// far side model: storage supply comparators, straps, pins, inputs
`timescale 1ns/1ps

module swtc_env
  import swtc_pkg::*;
(
  input  wire logic [11:0] vdd_mv,  // storage voltage, mV
  input  wire logic [10:0] pins,    // {sleep,wake,cw,cp,di}
  output      swtc_pin_t   pin_in   // levels seen by the block
);
  // comparators model the threshold detector thresholds
  assign pin_in.above_on  = vdd_mv > 12'h992;
  assign pin_in.above_off = vdd_mv > 12'h76C;
  // straps: 1 = open, 0 = grounded
  assign {pin_in.sleep, pin_in.wake, pin_in.cw, pin_in.cp, pin_in.di} = pins;
endmodule : swtc_env

// >>> dv/tb_sensor_wake_and_telegram_control.sv
// self-checking bench for the sensor wake and telegram control
`timescale 1ns/1ps

module tb_sensor_wake_and_telegram_control import swtc_pkg::*; ;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0]  wstrb = 4'hF;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic [11:0] vdd_mv = 12'h000;   // starts discharged
  logic [10:0] pins = 11'h03F;     // no cyclic wake, inputs high
  swtc_pin_t   pin_in;
  logic        cco_out, cco_oe, ulp_supply_en, watchdog_en;
  logic        wake_circ_en, shutdown_req, tg_valid;
  swtc_cfg_t   cfg_act;
  swtc_tg_t    tg;
  int          err_count = 0, cmp_count = 0, cyc = 0, n = 0;
  // rows: address, expected {resp, data} after reset
  localparam logic [41:0] ROWS [6] = '{{8'h00, 34'h0},
    {8'h04, 34'h1}, {8'h08, 34'hE07}, {8'h0C, 34'hE01406},
    {8'h10, 34'hF010}, {8'h24, 34'h200000000}};
  // wake cycle writes: {expected readback, written}
  localparam logic [63:0] WK [3] = '{{32'h1, 32'h0},
    {32'hFFFE, 32'hFFFE}, {32'hFFFE, 32'hFFFF}};

  swtc_top #(.TICK_CYCLES(10)) DUT (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .pin_in, .cco_out, .cco_oe, .ulp_supply_en, .watchdog_en,
    .wake_circ_en, .shutdown_req, .cfg_act, .tg, .tg_valid);
  swtc_env ENV (.vdd_mv, .pins, .pin_in);

  // 100 ns clock
  initial forever #50 aclk = ~aclk;

  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  // write; each half dropped at the edge that takes it, response in r
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw;
    ta      = 1'b0;
    tw      = 1'b0;
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!ta || !tw) begin
      @(posedge aclk);
      if (!ta && awready === 1'b1) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (!tw && wready === 1'b1) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    // idle edge, so a following call never re-raises bready here
    @(posedge aclk);
  endtask : axw

  // read; leaves data in d and response in r
  task automatic axr(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    // idle edge, so a following call never re-raises rready here
    @(posedge aclk);
  endtask : axr

  // wait for a telegram; e = {teach, retx, data}; n = cycles waited
  task automatic tgw(input logic [33:0] e);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (tg_valid !== 1'b1 && n < 60);
    chk({tg_valid, tg.telegram_type_field, tg.teach, tg.retx, tg.data, tg.id},
        {1'b1, 8'h07, e, 32'h1});
    @(posedge aclk);
  endtask : tgw

  task automatic results;
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  // hang guard, far above the few hundred cycles needed
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      results();
    end
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(cco_oe, 1'b0);
    @(posedge aclk);
    vdd_mv <= 12'hBB8;
    repeat (8) @(negedge aclk);
    chk({cco_oe, cco_out, ulp_supply_en, watchdog_en, wake_circ_en},
        5'h1F);
    @(posedge aclk);
    foreach (ROWS[i]) begin
      axr(ROWS[i][41:34]);
      chk({r, d}, ROWS[i][33:0]);
    end
    foreach (WK[i]) begin
      axw(8'h04, WK[i][31:0]);
      chk(r, 2'b00);
      axr(8'h04);
      chk(d, WK[i][63:32]);
    end
    // pin wakes on both edges, normal telegram
    pins <= 11'h13F;
    tgw({2'b00, 32'hF});
    pins <= 11'h03F;
    tgw({2'b00, 32'hF});
    // code programmed: input three low, then learn pin
    axw(8'h14, 32'h123456);
    chk(cfg_act.equipment_profile_code, 24'h0);
    axw(8'h00, 32'h60);
    pins <= 11'h137;
    tgw({2'b10, 32'h12345687});
    chk({cfg_act.mfr_ok, cfg_act.equipment_profile_code}, 25'h1123456);
    pins <= 11'h337;
    tgw({2'b10, 32'h12345687});
    // straps picked up at this wake: 1 s cycle, retransmit every wake
    pins <= 11'h2FF;
    tgw({2'b00, 32'hF});
    tgw({2'b01, 32'hF});
    tgw({2'b01, 32'hF});
    // programmed 2 s cycle and fixed count 2 win after module reset
    axw(8'h04, 32'h2);
    axw(8'h08, 32'h202);
    axw(8'h00, 32'h63);
    tgw({2'b01, 32'hF});
    tgw({2'b01, 32'hF});
    tgw({2'b01, 32'hF});
    // two timer wakes of two 10-cycle seconds between telegrams
    chk(n, 32'h28);
    chk({cfg_act.prog_wake, cfg_act.prog_retx, cfg_act.wake_s},
        18'h30002);
    // deep sleep freezes charge output while supply dips
    pins <= 11'h6FF;
    vdd_mv <= 12'h898;
    repeat (8) @(negedge aclk);
    chk({cco_oe, cco_out}, 2'b11);
    @(posedge aclk);
    pins <= 11'h2FF;
    repeat (8) @(negedge aclk);
    chk(cco_out, 1'b0);
    @(posedge aclk);
    vdd_mv <= 12'h5DC;
    repeat (8) @(negedge aclk);
    chk({shutdown_req, ulp_supply_en}, 2'b10);
    results();
  end
endmodule : tb_sensor_wake_and_telegram_control
